/* hw/lpmc_pkg.sv */
package lpmc_pkg;

    typedef enum logic [1:0] {
        LPMC_RUN     = 2'b00,
        LPMC_WAIT    = 2'b01,
        LPMC_STOP    = 2'b10,
        LPMC_RECOVER = 2'b11
    } lpmc_mode_t;

    // Register byte addresses
    localparam logic [3:0] LPMC_OFS_CTRL   = 4'h0;
    localparam logic [3:0] LPMC_OFS_CLKGEN = 4'h4;
    localparam logic [3:0] LPMC_OFS_STATUS = 4'h8;
    localparam logic [3:0] LPMC_OFS_WDOG   = 4'hC;

    // Control register fields
    localparam int LPMC_CTRL_STOP_EN   = 0;
    localparam int LPMC_CTRL_OSC_RUN   = 1;
    localparam int LPMC_CTRL_SHORT_REC = 2;
    localparam int LPMC_CTRL_EXT_MASK  = 3;
    localparam int LPMC_CTRL_KPD_MASK  = 4;
    localparam int LPMC_CTRL_BRK_EN    = 5;
    localparam int LPMC_CTRL_LVI_EN    = 6;
    localparam int LPMC_CTRL_LVI_RST   = 7;
    localparam int LPMC_CTRL_WDOG_EN   = 8;
    localparam int LPMC_CTRL_W         = 9;
    localparam logic [8:0] LPMC_CTRL_RST = 9'h0D8;

    // Clock generator register fields
    localparam int LPMC_CG_CM_ON   = 0;
    localparam int LPMC_CG_CM_IE   = 1;
    localparam int LPMC_CG_CM_FLAG = 2;
    localparam int LPMC_CG_EXT_STB = 3;
    localparam int LPMC_CG_INT_STB = 4;
    localparam int LPMC_CG_SET_LO  = 5;
    localparam int LPMC_CG_SET_W   = 21;
    localparam logic [20:0] LPMC_CG_SET_RST = 21'h004022;

    // Status register fields
    localparam int LPMC_ST_BRK_FLAG = 2;
    localparam int LPMC_ST_MASK     = 3;

    // Stop recovery in reference clock cycles
    localparam int LPMC_REC_W = 13;
    localparam logic [12:0] LPMC_REC_LONG  = 13'h1000;
    localparam logic [12:0] LPMC_REC_SHORT = 13'h0020;

    localparam int LPMC_WDOG_PRE_W = 8;
    localparam int LPMC_WDOG_CNT_W = 8;
    localparam int LPMC_NPIN       = 3;

endpackage : lpmc_pkg

/* hw/lpmc_low_power_ctrl.sv */
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module lpmc_low_power_ctrl (
    input  wire logic        core_clk,         // 25 MHz clock, also reference
    input  wire logic        nrst,             // Async reset, active low
    input  wire logic        ce,               // Clock enable, freezes state
    input  wire logic        hsel,             // AHB slave select
    input  wire logic [31:0] haddr,            // AHB address
    input  wire logic [1:0]  htrans,           // AHB transfer type
    input  wire logic        hwrite,           // AHB write
    input  wire logic [2:0]  hsize,            // AHB size
    input  wire logic [31:0] hwdata,           // AHB write data
    input  wire logic        hready,           // AHB bus ready
    output logic             hreadyout,        // AHB slave ready
    output logic             hresp,            // AHB response, always OKAY
    output logic [31:0]      hrdata,           // AHB read data
    input  wire logic        waitExec,         // CPU executes wait, pulse
    input  wire logic        stopExec,         // CPU executes stop, pulse
    input  wire logic        maskSetReq,       // CPU sets interrupt mask, pulse
    input  wire logic        extIrqPin,        // External interrupt request, async
    input  wire logic        keypadIrqPin,     // Keypad interrupt request, async
    input  wire logic        lviLowPin,        // Supply below trip, async
    input  wire logic        breakMatch,       // Breakpoint match, level
    input  wire logic        clkGenIrq,        // Enabled clock generator irq
    input  wire logic        asyncSerialIrq,   // Enabled async serial irq
    input  wire logic        syncSerialIrq,    // Enabled sync serial irq
    input  wire logic        timebaseIrq,      // Enabled timebase irq
    input  wire logic        extOscReady,      // External clock stable
    input  wire logic        intOscReady,      // Internal clock stable
    input  wire logic        clkMonFault,      // Clock monitor fault
    output logic             cpuClkEn,         // CPU clock enable
    output logic             busClkEn,         // Bus clock enable
    output logic             refClkEn,         // Reference clock enable
    output logic             wdogClkEn,        // Watchdog clock enable
    output logic             tbClkEn,          // Timebase clock enable
    output logic             breakUnitEn,      // Breakpoint unit enable
    output logic             asyncSerialEn,    // Async serial run enable
    output logic             syncSerialEn,     // Sync serial run enable
    output logic             syncSerialAbort,  // Sync serial abort pulse
    output logic             lviActive,        // Voltage monitor powered
    output logic             irqMask,          // CPU interrupt mask
    output logic             clkMonOn,         // Clock monitor enable
    output logic             clkMonIrq,        // Clock monitor interrupt
    output logic             wakeReq,          // Wake pulse
    output logic             sysResetReq       // System reset request
);

    typedef struct packed {
        lpmc_pkg::lpmc_mode_t                  mode;
        logic [lpmc_pkg::LPMC_CTRL_W-1:0]      ctrl;
        logic                                  clock_monitor_on;
        logic                                  clock_monitor_irq_enable;
        logic                                  cmFlag;
        logic                                  extStb;
        logic                                  intStb;
        logic [lpmc_pkg::LPMC_CG_SET_W-1:0]    cgSet;
        logic                                  brkFlag;
        logic                                  mask;
        logic [lpmc_pkg::LPMC_REC_W-1:0]       recCnt;
        logic [lpmc_pkg::LPMC_WDOG_PRE_W-1:0]  wdPre;
        logic [lpmc_pkg::LPMC_WDOG_CNT_W-1:0]  wdCnt;
        logic [lpmc_pkg::LPMC_NPIN-1:0]        sy1;
        logic [lpmc_pkg::LPMC_NPIN-1:0]        sy2;
        logic [lpmc_pkg::LPMC_NPIN-1:0]        sy3;
        logic [lpmc_pkg::LPMC_NPIN-1:0]        pin;
        logic                                  apValid;
        logic                                  apWrite;
        logic [3:0]                            apAddr;
        logic [31:0]                           rdata;
        logic                                  wake;
        logic                                  rstReq;
        logic                                  abort;
        logic                                  cpuEn;
        logic                                  busEn;
        logic                                  refEn;
        logic                                  wdEn;
        logic                                  brkEn;
        logic                                  serEn;
    } lpmc_state_t;

    lpmc_state_t s;
    lpmc_state_t next_s;

    logic [lpmc_pkg::LPMC_NPIN-1:0] rawPins;
    logic [lpmc_pkg::LPMC_NPIN-1:0] pinSettled;
    logic                           extReq;
    logic                           kpdReq;
    logic                           lviTrip;
    logic                           wdTimeout;
    logic                           wakeWait;
    logic                           wakeStop;
    logic                           brkEnable;
    logic                           oscRun;
    logic                           stopEntry;
    logic                           busWr;
    logic [31:0]                    regView;

    assign rawPins = {lviLowPin, keypadIrqPin, extIrqPin};

    // Pin inputs settle only when second and third stage agree
    genvar gi;
    for (gi = 0; gi < lpmc_pkg::LPMC_NPIN; gi++) begin : g_pin
        assign pinSettled[gi] = (s.sy2[gi] == s.sy3[gi]) ? s.sy3[gi] : s.pin[gi];
    end

    assign oscRun    = s.ctrl[lpmc_pkg::LPMC_CTRL_OSC_RUN];
    assign brkEnable = s.ctrl[lpmc_pkg::LPMC_CTRL_BRK_EN];
    assign extReq    = s.pin[0] & ~s.ctrl[lpmc_pkg::LPMC_CTRL_EXT_MASK];
    assign kpdReq    = s.pin[1] & ~s.ctrl[lpmc_pkg::LPMC_CTRL_KPD_MASK];
    // Monitor tracks the supply in every mode while enabled
    assign lviTrip   = s.pin[2] & s.ctrl[lpmc_pkg::LPMC_CTRL_LVI_EN]
                     & s.ctrl[lpmc_pkg::LPMC_CTRL_LVI_RST];
    assign wdTimeout = s.ctrl[lpmc_pkg::LPMC_CTRL_WDOG_EN] & (&s.wdCnt)
                     & (&s.wdPre);

    // Wait wakes from any enabled peripheral interrupt
    assign wakeWait = extReq | kpdReq | (brkEnable & breakMatch)
                    | clkGenIrq
                    | asyncSerialIrq
                    | syncSerialIrq
                    | timebaseIrq;
    // Clock generator interrupts deliberately excluded from stop wake
    assign wakeStop = extReq | kpdReq | (brkEnable & breakMatch)
                    | (oscRun & timebaseIrq);

    assign stopEntry = (s.mode == lpmc_pkg::LPMC_RUN) & stopExec
                     & s.ctrl[lpmc_pkg::LPMC_CTRL_STOP_EN];

    assign busWr = s.apValid & s.apWrite;

    always_comb begin
        regView = 32'h0000_0000;
        unique case (haddr[3:0])
            lpmc_pkg::LPMC_OFS_CTRL: begin
                regView[lpmc_pkg::LPMC_CTRL_W-1:0] = s.ctrl;
            end
            lpmc_pkg::LPMC_OFS_CLKGEN: begin
                regView[lpmc_pkg::LPMC_CG_CM_ON]   = s.clock_monitor_on;
                regView[lpmc_pkg::LPMC_CG_CM_IE]   = s.clock_monitor_irq_enable;
                regView[lpmc_pkg::LPMC_CG_CM_FLAG] = s.cmFlag;
                regView[lpmc_pkg::LPMC_CG_EXT_STB] = s.extStb;
                regView[lpmc_pkg::LPMC_CG_INT_STB] = s.intStb;
                regView[25:5]                      = s.cgSet;
            end
            lpmc_pkg::LPMC_OFS_STATUS: begin
                regView[1:0]                        = s.mode;
                regView[lpmc_pkg::LPMC_ST_BRK_FLAG] = s.brkFlag;
                regView[lpmc_pkg::LPMC_ST_MASK]     = s.mask;
            end
            lpmc_pkg::LPMC_OFS_WDOG: begin
                regView[lpmc_pkg::LPMC_WDOG_CNT_W-1:0] = s.wdCnt;
            end
            default: begin
                regView = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        next_s.mode    = s.mode;
        next_s.ctrl    = s.ctrl;
        next_s.clock_monitor_on    = s.clock_monitor_on;
        next_s.clock_monitor_irq_enable    = s.clock_monitor_irq_enable;
        next_s.cmFlag  = s.cmFlag;
        next_s.extStb  = s.extStb | extOscReady;
        next_s.intStb  = s.intStb | intOscReady;
        next_s.cgSet   = s.cgSet;
        next_s.brkFlag = s.brkFlag;
        next_s.mask    = s.mask | maskSetReq;
        next_s.recCnt  = s.recCnt;
        next_s.wdPre   = s.wdPre;
        next_s.wdCnt   = s.wdCnt;
        next_s.sy1     = rawPins;
        next_s.sy2     = s.sy1;
        next_s.sy3     = s.sy2;
        // Only the single state process writes the copy
        next_s.pin     = pinSettled;
        next_s.apValid = hsel & hready & htrans[1] & (haddr[1:0] == 2'b00)
                       & (hsize == 3'b010);
        next_s.apWrite = hwrite;
        next_s.apAddr  = haddr[3:0];
        next_s.rdata   = (hsel & hready & ~hwrite) ? regView : s.rdata;
        next_s.wake    = 1'b0;
        next_s.abort   = 1'b0;

        // Register writes in the data phase
        if (busWr) begin
            unique case (s.apAddr)
                lpmc_pkg::LPMC_OFS_CTRL: begin
                    next_s.ctrl = hwdata[lpmc_pkg::LPMC_CTRL_W-1:0];
                end
                lpmc_pkg::LPMC_OFS_CLKGEN: begin
                    next_s.clock_monitor_on  = hwdata[lpmc_pkg::LPMC_CG_CM_ON];
                    next_s.clock_monitor_irq_enable  = hwdata[lpmc_pkg::LPMC_CG_CM_IE];
                    next_s.cgSet = hwdata[25:5];
                    if (hwdata[lpmc_pkg::LPMC_CG_CM_FLAG]) begin
                        next_s.cmFlag = 1'b0;
                    end
                end
                lpmc_pkg::LPMC_OFS_STATUS: begin
                    if (hwdata[lpmc_pkg::LPMC_ST_BRK_FLAG]) begin
                        next_s.brkFlag = 1'b0;
                    end
                end
                lpmc_pkg::LPMC_OFS_WDOG: begin
                    next_s.wdCnt = '0;
                    next_s.wdPre = '0;
                end
                default: begin
                    next_s.ctrl = s.ctrl;
                end
            endcase
        end

        // Hardware sets placed after the register write clears so a coincident event wins over a write
        if (s.clock_monitor_on & clkMonFault) begin
            next_s.cmFlag = 1'b1;
        end

        // Watchdog counts whenever its clock runs, wait included
        if (s.wdEn & s.ctrl[lpmc_pkg::LPMC_CTRL_WDOG_EN]
            & ~(busWr & (s.apAddr == lpmc_pkg::LPMC_OFS_WDOG))) begin
            next_s.wdPre = s.wdPre + 1'b1;
            if (&s.wdPre) begin
                next_s.wdCnt = s.wdCnt + 1'b1;
            end
        end

        unique case (s.mode)
            lpmc_pkg::LPMC_RUN: begin
                if (waitExec) begin
                    next_s.mode = lpmc_pkg::LPMC_WAIT;
                    next_s.mask = 1'b0;
                end else if (stopEntry) begin
                    next_s.mode  = lpmc_pkg::LPMC_STOP;
                    next_s.mask  = 1'b0;
                    next_s.wdPre = '0;
                    // Settings in cgSet untouched across stop
                    if (~oscRun) begin
                        next_s.extStb = 1'b0;
                        next_s.intStb = 1'b0;
                        next_s.clock_monitor_on   = 1'b0;
                        next_s.clock_monitor_irq_enable   = 1'b0;
                        next_s.cmFlag = 1'b0;
                    end
                end
            end
            lpmc_pkg::LPMC_WAIT: begin
                if (wakeWait) begin
                    // Mask left clear on interrupt exit
                    next_s.mode = lpmc_pkg::LPMC_RUN;
                    next_s.wake = 1'b1;
                    if (brkEnable & breakMatch) begin
                        next_s.brkFlag = 1'b1;
                    end
                end
            end
            lpmc_pkg::LPMC_STOP: begin
                next_s.wdPre = '0;
                if (~oscRun) begin
                    next_s.extStb = 1'b0;
                    next_s.intStb = 1'b0;
                end
                if (wakeStop) begin
                    next_s.mode   = lpmc_pkg::LPMC_RECOVER;
                    next_s.recCnt = s.ctrl[lpmc_pkg::LPMC_CTRL_SHORT_REC]
                                  ? lpmc_pkg::LPMC_REC_SHORT
                                  : lpmc_pkg::LPMC_REC_LONG;
                    if (brkEnable & breakMatch) begin
                        next_s.brkFlag = 1'b1;
                    end
                end
            end
            lpmc_pkg::LPMC_RECOVER: begin
                next_s.recCnt = s.recCnt - 1'b1;
                if (s.recCnt == 13'h0001) begin
                    next_s.mode = lpmc_pkg::LPMC_RUN;
                    next_s.wake = 1'b1;
                end
            end
        endcase

        // A reset request ends any mode; the device reset then sets the mask
        next_s.rstReq = lviTrip | wdTimeout;
        if ((lviTrip | wdTimeout) & ~s.rstReq
            & ((s.mode == lpmc_pkg::LPMC_STOP) | (s.mode == lpmc_pkg::LPMC_RECOVER))) begin
            next_s.abort = 1'b1;
        end

        // Clock gating derived from the mode being entered
        next_s.cpuEn = (next_s.mode == lpmc_pkg::LPMC_RUN);
        next_s.busEn = (next_s.mode == lpmc_pkg::LPMC_RUN)
                     | (next_s.mode == lpmc_pkg::LPMC_WAIT)
                     | ((next_s.mode == lpmc_pkg::LPMC_STOP)
                        & next_s.ctrl[lpmc_pkg::LPMC_CTRL_OSC_RUN]);
        next_s.refEn = ~((next_s.mode == lpmc_pkg::LPMC_STOP)
                         & ~next_s.ctrl[lpmc_pkg::LPMC_CTRL_OSC_RUN]);
        next_s.wdEn  = (next_s.mode == lpmc_pkg::LPMC_RUN)
                     | (next_s.mode == lpmc_pkg::LPMC_WAIT);
        next_s.brkEn = next_s.ctrl[lpmc_pkg::LPMC_CTRL_BRK_EN]
                     & (next_s.mode != lpmc_pkg::LPMC_STOP);
        next_s.serEn = (next_s.mode == lpmc_pkg::LPMC_RUN)
                     | (next_s.mode == lpmc_pkg::LPMC_WAIT);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s         <= '0;
            s.mode    <= lpmc_pkg::LPMC_RUN;
            s.ctrl    <= lpmc_pkg::LPMC_CTRL_RST;
            s.cgSet   <= lpmc_pkg::LPMC_CG_SET_RST;
            s.mask    <= 1'b1;
            s.cpuEn   <= 1'b1;
            s.busEn   <= 1'b1;
            s.refEn   <= 1'b1;
            s.wdEn    <= 1'b1;
            s.serEn   <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

    // Stall the bus while frozen so no transfer is lost
    assign hreadyout       = ce;
    assign hresp           = 1'b0;
    assign hrdata          = s.rdata;
    assign cpuClkEn        = s.cpuEn;
    assign busClkEn        = s.busEn;
    assign refClkEn        = s.refEn;
    assign wdogClkEn       = s.wdEn;
    assign tbClkEn         = s.busEn;
    assign breakUnitEn     = s.brkEn;
    assign asyncSerialEn   = s.serEn;
    assign syncSerialEn    = s.serEn;
    assign syncSerialAbort = s.abort;
    assign lviActive       = s.ctrl[lpmc_pkg::LPMC_CTRL_LVI_EN];
    assign irqMask         = s.mask;
    assign clkMonOn        = s.clock_monitor_on;
    assign clkMonIrq       = s.clock_monitor_irq_enable & s.cmFlag;
    assign wakeReq         = s.wake;
    assign sysResetReq     = s.rstReq;

endmodule : lpmc_low_power_ctrl
`default_nettype wire

/* dv/lpmc_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module lpmc_checker (
    input wire logic core_clk,        // clock
    input wire logic nrst,            // reset, low
    input wire logic waitExec,        // wait pulse
    input wire logic cpuClkEn,        // cpu clock
    input wire logic busClkEn,        // bus clock
    input wire logic refClkEn,        // ref clock
    input wire logic wdogClkEn,       // watchdog clock
    input wire logic tbClkEn,         // timebase clock
    input wire logic breakUnitEn,     // break unit
    input wire logic asyncSerialEn,   // async serial
    input wire logic syncSerialEn,    // sync serial
    input wire logic syncSerialAbort, // abort pulse
    input wire logic irqMask,         // cpu mask
    input wire logic wakeReq,         // wake pulse
    input wire logic sysResetReq      // reset request
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    property p_waitEntry; waitExec && cpuClkEn |=> !cpuClkEn && busClkEn && !irqMask; endproperty
    a_waitEntry: assert property (p_waitEntry) else $error("bad wait entry");
    property p_maskOnGate; $fell(cpuClkEn) |-> !irqMask; endproperty
    a_maskOnGate: assert property (p_maskOnGate) else $error("mask set at gating");
    property p_wakeOn; wakeReq |-> cpuClkEn && busClkEn; endproperty
    a_wakeOn: assert property (p_wakeOn) else $error("wake with clocks off");
    property p_refGate; !refClkEn |-> !busClkEn && !wdogClkEn && !tbClkEn && !cpuClkEn; endproperty
    a_refGate: assert property (p_refGate) else $error("clock runs in stop");
    // Ref clock back means recovery began; cpu still held 30 cycles on, inside the 32-cycle short count
    property p_recovery; $rose(refClkEn) |-> ##30 !cpuClkEn; endproperty
    a_recovery: assert property (p_recovery) else $error("recovery too short");
    property p_abort; syncSerialAbort |-> sysResetReq && !cpuClkEn; endproperty
    a_abort: assert property (p_abort) else $error("stray abort");
    property p_stopHalt; !refClkEn |-> !breakUnitEn && !asyncSerialEn && !syncSerialEn; endproperty
    a_stopHalt: assert property (p_stopHalt) else $error("unit runs in stop");
    property p_waitRun; !cpuClkEn && busClkEn && asyncSerialEn |-> wdogClkEn && syncSerialEn; endproperty
    a_waitRun: assert property (p_waitRun) else $error("unit halted in wait");
endmodule : lpmc_checker
bind lpmc_low_power_ctrl lpmc_checker u_chk (.core_clk, .nrst, .waitExec, .cpuClkEn, .busClkEn,
    .refClkEn, .wdogClkEn, .tbClkEn, .breakUnitEn, .asyncSerialEn, .syncSerialEn,
    .syncSerialAbort, .irqMask, .wakeReq, .sysResetReq);
`default_nettype wire

/* dv/lpmc_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module lpmc_cpu_model (
    input  wire logic       core_clk,        // clock
    input  wire logic       cpuClkEn,        // cpu clock enable
    input  wire logic [1:0] cmd,             // 1 wait, 2 stop
    output logic            waitExec = 1'b0, // wait executed
    output logic            stopExec = 1'b0  // stop executed
);
    // A gated core executes nothing
    always @(posedge core_clk) begin
        waitExec <= cmd == 2'd1 && cpuClkEn;
        stopExec <= cmd == 2'd2 && cpuClkEn;
    end
endmodule : lpmc_cpu_model
`default_nettype wire

/* dv/low_power_mode_controller_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module low_power_mode_controller_tb_top;
    logic        core_clk = 1'b0;
    logic        nrst     = 1'b0;
    logic        hsel     = 1'b0;
    logic        hwrite   = 1'b0;
    logic        lviLow   = 1'b0;
    logic        clkEvt   = 1'b0;
    logic        w;
    logic [1:0]  htrans   = 2'b00;
    logic [1:0]  cmd      = 2'b00;
    logic [6:0]  src      = 7'h00;
    logic [31:0] haddr    = 32'h0;
    logic [31:0] hwdata   = 32'h0;
    logic [31:0] rd;
    wire logic   hreadyout, waitExec, stopExec, cpuClkEn, busClkEn, refClkEn, wdogClkEn;
    wire logic   tbClkEn, breakUnitEn, asyncSerialEn, syncSerialEn, syncSerialAbort, irqMask;
    wire logic   clkMonOn, wakeReq, sysResetReq, clkMonIrq, lviActive, hresp;
    wire logic [31:0] hrdata;
    int numErrors = 0;
    int numChecks = 0;
    int n;
    // {stop, wakes, timebase sync async clkgen break keypad ext}
    localparam logic [8:0] ROWS [14] = '{9'h081, 9'h082, 9'h084, 9'h088, 9'h090, 9'h0A0,
        9'h0C0, 9'h181, 9'h182, 9'h184, 9'h1C0, 9'h108, 9'h110, 9'h120};
    always #20 core_clk = ~core_clk;
    lpmc_cpu_model cpu (.core_clk, .cpuClkEn, .cmd, .waitExec, .stopExec);
    lpmc_low_power_ctrl uut (.core_clk, .nrst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .waitExec,
        .stopExec, .maskSetReq(1'b0), .extIrqPin(src[0]), .keypadIrqPin(src[1]),
        .lviLowPin(lviLow), .breakMatch(src[2]), .clkGenIrq(src[3]), .asyncSerialIrq(src[4]),
        .syncSerialIrq(src[5]), .timebaseIrq(src[6]), .extOscReady(clkEvt), .intOscReady(1'b0),
        .clkMonFault(clkEvt), .cpuClkEn, .busClkEn, .refClkEn, .wdogClkEn, .tbClkEn, .breakUnitEn,
        .asyncSerialEn, .syncSerialEn, .syncSerialAbort, .lviActive, .irqMask, .clkMonOn,
        .clkMonIrq, .wakeReq, .sysResetReq);
    task automatic report_and_stop;
        $display("checks %0d errors %0d", numChecks, numErrors);
        if (numErrors == 0 && numChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        numChecks++;
        if (g !== e) begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdy;
        for (int i = 0; i < 1 || (hreadyout !== 1'b1 && i < 9); i++) @(posedge core_clk);
        if (hreadyout !== 1'b1) begin
            numErrors++;
            report_and_stop;
        end
    endtask : rdy
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask : xfer
    task automatic exec(input logic [1:0] c);
        cmd <= c;
        @(posedge core_clk);
        cmd <= 2'b00;
        repeat (2) @(posedge core_clk);
    endtask : exec
    task automatic wake;
        w = 1'b0;
        for (n = 0; n < 100 && !w; n++) begin
            @(posedge core_clk);
            w = wakeReq === 1'b1;
        end
    endtask : wake
    initial begin
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        xfer(1'b0, 32'h0, 32'h0);
        chk("ctrl", 32'h0D8, rd);
        xfer(1'b1, 32'h0, 32'h0E7);
        foreach (ROWS[i]) begin
            exec(ROWS[i][8] ? 2'd2 : 2'd1);
            chk("lowPower", {3'b001, {2{!ROWS[i][8]}}},
                {cpuClkEn, irqMask, busClkEn, asyncSerialEn, breakUnitEn});
            src <= ROWS[i][6:0];
            wake();
            chk("wake", ROWS[i][7], w);
            if (!w) begin
                src <= 7'h01;
                wake();
                chk("extWake", 1, w);
            end
            src <= 7'h00;
            chk("irqMask", 0, irqMask);
            repeat (6) @(posedge core_clk);
        end
        xfer(1'b0, 32'h8, 32'h0);
        chk("status", 32'h4, rd);
        chk("hresp", 0, hresp);
        xfer(1'b1, 32'h0, 32'h0C5);
        xfer(1'b1, 32'h4, 32'h80443);
        xfer(1'b1, 32'hC, 32'h0);
        // Raise stable and monitor flags so that the stop below has work to clear
        clkEvt <= 1'b1;
        @(posedge core_clk);
        clkEvt <= 1'b0;
        xfer(1'b0, 32'h4, 32'h0);
        chk("clkgenSet", 32'h8044F, rd);
        chk("clkMonIrq", 1, clkMonIrq);
        exec(2'd2);
        chk("stopClocks", 0, {refClkEn, busClkEn, wdogClkEn, tbClkEn, clkMonOn, clkMonIrq});
        src <= 7'h02;
        wake();
        chk("keypadWake", 1, w);
        src <= 7'h00;
        xfer(1'b0, 32'h4, 32'h0);
        chk("clkgen", 32'h80440, rd);
        exec(2'd2);
        chk("lviActive", 1, lviActive);
        lviLow <= 1'b1;
        for (n = 0; n < 20 && sysResetReq !== 1'b1; n++) @(posedge core_clk);
        chk("sysResetReq", 1, sysResetReq);
        nrst <= 1'b0;
        lviLow <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        chk("irqMask", 1, irqMask);
        exec(2'd2);
        chk("cpuClkEn", 1, cpuClkEn);
        report_and_stop;
    end
endmodule : low_power_mode_controller_tb_top
`default_nettype wire
